// [hw/adc_frame_ctrl.sv]
// Purpose: framing, conversion sequencing and power control of a serial converter
// Assumes: link pins asynchronous to clk_i, sampled by two flops each
// Notes: converter result comes from the SAMPLE register; bus is zero-wait
`timescale 1ns/1ps
module adc_frame_ctrl #(
	parameter int POR_CYC = adc_ctrl_pkg::POR_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Serial link
	input wire logic shift_clock_i,
	input wire logic select_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	output logic conversion_strobe_o,
	output logic conversion_strobe_oe_o,
	// Three-state shutdown pin, sensed as level plus float
	input wire logic hw_shutdown_n_i,
	input wire logic hw_shutdown_float_i
);
	if (POR_CYC < 2 || POR_CYC > 65535) begin : g_chk
		$error("POR_CYC out of range");
	end

	adc_ctrl_pkg::state_s r;
	adc_ctrl_pkg::state_s n;
	adc_ctrl_pkg::pins_s pins;
	adc_ctrl_pkg::status_s status;
	logic rise;
	logic fall;
	logic cs_low;
	logic cs_rise;
	logic hw_shutdown_n_low;
	logic armed;
	logic start;
	logic finish;
	logic take;
	logic [15:0] step_len;

	assign pins = '{sclk: shift_clock_i, cs_n: select_n_i, din: serial_in_i,
		hw_shutdown_n_n: hw_shutdown_n_i, hw_shutdown_n_fl: hw_shutdown_float_i};
	assign rise = r.s2.sclk & ~r.sclk_d;
	assign fall = ~r.s2.sclk & r.sclk_d;
	assign cs_low = ~r.s2.cs_n;
	assign cs_rise = r.s2.cs_n & ~r.cs_n_d;
	assign hw_shutdown_n_low = ~r.s2.hw_shutdown_n_fl & ~r.s2.hw_shutdown_n_n;
	// Float selects the fast internal clock
	assign step_len = r.s2.hw_shutdown_n_fl ? adc_ctrl_pkg::STEP_FAST : adc_ctrl_pkg::STEP_SLOW;
	assign armed = (r.st == adc_ctrl_pkg::ST_IDLE) | r.toggled
		| (r.st == adc_ctrl_pkg::ST_CONV & r.clk_ext
		& r.out_cnt >= adc_ctrl_pkg::ARM_BITS);
	assign start = fall & (r.rx_cnt == adc_ctrl_pkg::CTRL_BITS) & ~hw_shutdown_n_low;
	assign finish = (r.st == adc_ctrl_pkg::ST_CONV) & (r.clk_ext
		? (fall & r.out_cnt == adc_ctrl_pkg::OUT_BITS - 4'h1)
		: (r.cnt == step_len - 16'h1 & r.step == adc_ctrl_pkg::SAR_STEPS - 4'h1));
	assign take = hsel_i & htrans_i[1] & hready_i;

	always_comb begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.sclk_d = r.s2.sclk;
		n.cs_n_d = r.s2.cs_n;
		n.wr_pend = take & hwrite_i;
		if (take) begin
			n.wr_addr = haddr_i[3:0];
		end
		if (take & ~hwrite_i) begin
			case (haddr_i[3:0])
				adc_ctrl_pkg::OFS_SAMPLE: n.rdata = 32'(r.sample);
				adc_ctrl_pkg::OFS_STATUS: n.rdata = 32'(status);
				adc_ctrl_pkg::OFS_CTRL: n.rdata = 32'(r.ctrl);
				adc_ctrl_pkg::OFS_RESULT: n.rdata = 32'(r.result);
				default: n.rdata = 32'h0;
			endcase
		end
		if (r.wr_pend && r.wr_addr == adc_ctrl_pkg::OFS_SAMPLE) begin
			n.sample = hwdata_i[adc_ctrl_pkg::RESULT_W-1:0];
		end

		if (cs_rise && r.st == adc_ctrl_pkg::ST_CONV) begin
			n.toggled = 1'b1;
		end
		// Shifter runs in standby too, so results stay readable
		if (fall) begin
			n.dout = r.shreg[15];
			n.shreg = {r.shreg[14:0], 1'b0};
			if (r.out_cnt != adc_ctrl_pkg::OUT_BITS) begin
				n.out_cnt = r.out_cnt + 4'h1;
			end
			if (r.clk_ext && r.st == adc_ctrl_pkg::ST_CONV) begin
				n.strobe = 1'b0;
			end
		end
		// Select high or start bit not yet seen: nothing is shifted in
		if (!cs_low) begin
			n.rx_cnt = 4'h0;
		end else if (rise) begin
			if (r.rx_cnt == 4'h0) begin
				if (r.s2.din && armed) begin
					n.rx_cnt = 4'h1;
					n.rx = 8'h01;
					n.pdown = 1'b0;
				end
			end else if (r.rx_cnt < adc_ctrl_pkg::CTRL_BITS) begin
				n.rx = {r.rx[6:0], r.s2.din};
				n.rx_cnt = r.rx_cnt + 4'h1;
			end
		end

		case (r.st)
			adc_ctrl_pkg::ST_POR: begin
				n.rx_cnt = 4'h0;
				n.cnt = r.cnt + 16'h1;
				if (r.cnt == 16'(POR_CYC - 1)) begin
					n.st = adc_ctrl_pkg::ST_IDLE;
					n.cnt = 16'h0;
				end
			end
			adc_ctrl_pkg::ST_IDLE: begin
				n.cnt = 16'h0;
			end
			adc_ctrl_pkg::ST_CONV: begin
				if (!r.clk_ext) begin
					n.cnt = r.cnt + 16'h1;
					if (r.cnt == step_len - 16'h1) begin
						n.cnt = 16'h0;
						n.step = r.step + 4'h1;
					end
				end
				if (finish) begin
					n.st = adc_ctrl_pkg::ST_IDLE;
					n.toggled = 1'b0;
					n.converted = 1'b1;
					n.result = {r.sample, 2'b00};
					n.pdown = ~r.mode[1];
					if (!r.clk_ext) begin
						n.strobe = 1'b1;
						n.shreg = {r.sample, 6'h00};
						n.out_cnt = 4'h0;
					end
				end
			end
			adc_ctrl_pkg::ST_DOWN: begin
				if (!hw_shutdown_n_low) begin
					n.st = adc_ctrl_pkg::ST_IDLE;
				end
			end
			default: n.st = adc_ctrl_pkg::ST_IDLE;
		endcase

		if (start) begin
			n.rx_cnt = 4'h0;
			n.ctrl = r.rx;
			n.mode = adc_ctrl_pkg::pmode_e'(r.rx[1:0]);
			// Standby codes keep the previous clock mode
			n.clk_ext = r.rx[1] ? r.rx[0] : r.clk_ext;
			n.st = adc_ctrl_pkg::ST_CONV;
			n.toggled = 1'b0;
			// A start always runs powered, even if standby was just re-armed
			n.pdown = 1'b0;
			n.cnt = 16'h0;
			n.step = 4'h0;
			n.out_cnt = 4'h0;
			n.dout = 1'b0;
			if (r.rx[1] ? r.rx[0] : r.clk_ext) begin
				n.strobe = 1'b1;
				n.shreg = {r.sample, 6'h00};
			end else begin
				n.strobe = 1'b0;
				n.shreg = 16'h0;
			end
		end
		// Hard shutdown wins over state, framing and strobe; a finish in the same cycle still completes
		if (hw_shutdown_n_low) begin
			n.st = adc_ctrl_pkg::ST_DOWN;
			n.rx_cnt = 4'h0;
			n.toggled = 1'b0;
			n.cnt = 16'h0;
			n.strobe = ~r.clk_ext;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.mode <= adc_ctrl_pkg::PM_INT;
			r.strobe <= 1'b1;
			r.st <= adc_ctrl_pkg::ST_POR;
			// Pins idle high: no false select edge or shutdown right after reset
			r.s1.cs_n <= 1'b1;
			r.s2.cs_n <= 1'b1;
			r.cs_n_d <= 1'b1;
			r.s1.hw_shutdown_n_n <= 1'b1;
			r.s2.hw_shutdown_n_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	always_comb begin
		status = '0;
		status.converted = r.converted;
		status.strobe = r.strobe;
		status.ready = (r.st != adc_ctrl_pkg::ST_POR);
		status.hw_down = (r.st == adc_ctrl_pkg::ST_DOWN);
		status.busy = (r.st == adc_ctrl_pkg::ST_CONV);
		status.pdown = r.pdown;
		status.clk_ext = r.clk_ext;
		status.mode = r.mode;
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = r.rdata;
	assign serial_out_o = r.dout;
	assign serial_out_oe_o = cs_low;
	assign conversion_strobe_o = r.strobe;
	assign conversion_strobe_oe_o = r.clk_ext ? cs_low : 1'b1;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_no_start_without_one;
		(cs_low && rise && r.rx_cnt == 4'h0 && !r.s2.din) |=> r.rx_cnt == 4'h0;
	endproperty
	a_no_start_without_one: assert property (p_no_start_without_one)
		else $error("start taken without a one");
	property p_conv_after_eighth;
		(r.st != adc_ctrl_pkg::ST_CONV) ##1 (r.st == adc_ctrl_pkg::ST_CONV)
		|-> $past(fall) && $past(r.rx_cnt) == adc_ctrl_pkg::CTRL_BITS;
	endproperty
	a_conv_after_eighth: assert property (p_conv_after_eighth)
		else $error("conversion began off the eighth-bit fall");
	property p_idle_start;
		(r.st == adc_ctrl_pkg::ST_IDLE && cs_low && rise && r.s2.din
		&& r.rx_cnt == 4'h0 && !hw_shutdown_n_low) |=> r.rx_cnt == 4'h1;
	endproperty
	a_idle_start: assert property (p_idle_start)
		else $error("idle start bit missed");
	property p_no_early_start;
		(r.st == adc_ctrl_pkg::ST_CONV && r.clk_ext && !r.toggled
		&& r.out_cnt < adc_ctrl_pkg::ARM_BITS && rise && r.rx_cnt == 4'h0)
		|=> r.rx_cnt == 4'h0;
	endproperty
	a_no_early_start: assert property (p_no_early_start)
		else $error("start bit taken before result bit 3");
	property p_toggle_arms;
		(cs_rise && r.st == adc_ctrl_pkg::ST_CONV && !hw_shutdown_n_low && !finish && !start)
		|=> r.toggled;
	endproperty
	a_toggle_arms: assert property (p_toggle_arms)
		else $error("select toggle not recorded");
	property p_reset_state;
		$rose(rst_n_i) |-> r.strobe && r.mode == adc_ctrl_pkg::PM_INT && !r.clk_ext;
	endproperty
	a_reset_state: assert property (@(posedge clk_i) p_reset_state)
		else $error("wrong state after reset");
	property p_por_length;
		$fell(r.st == adc_ctrl_pkg::ST_POR) && r.st == adc_ctrl_pkg::ST_IDLE
		|-> $past(r.cnt) == 16'(POR_CYC - 1);
	endproperty
	a_por_length: assert property (p_por_length)
		else $error("reset period wrong length");
	property p_zeros_first;
		!r.converted && r.st != adc_ctrl_pkg::ST_CONV |-> !r.dout;
	endproperty
	a_zeros_first: assert property (p_zeros_first)
		else $error("nonzero output before first conversion");
	property p_hw_stop;
		hw_shutdown_n_low |=> r.st == adc_ctrl_pkg::ST_DOWN ##1 r.st != adc_ctrl_pkg::ST_CONV;
	endproperty
	a_hw_stop: assert property (p_hw_stop)
		else $error("shutdown did not stop conversion");
	property p_int_strobe;
		(start && !(r.rx[1] ? r.rx[0] : r.clk_ext)) |=> !r.strobe [*2];
	endproperty
	a_int_strobe: assert property (p_int_strobe)
		else $error("internal strobe not low at start");
	property p_ext_strobe;
		(start && (r.rx[1] ? r.rx[0] : r.clk_ext)) |=> r.strobe ##[1:1000] !r.strobe;
	endproperty
	a_ext_strobe: assert property (p_ext_strobe)
		else $error("external strobe pulse wrong");
	property p_standby_after;
		(finish && !r.mode[1] && !hw_shutdown_n_low && !start) |=> r.pdown;
	endproperty
	a_standby_after: assert property (p_standby_after)
		else $error("standby not re-entered");
	property p_standby_idle;
		r.pdown |-> r.st != adc_ctrl_pkg::ST_CONV;
	endproperty
	a_standby_idle: assert property (p_standby_idle)
		else $error("conversion running in standby");
	property p_ignore_deselected;
		!cs_low |=> r.rx == $past(r.rx);
	endproperty
	a_ignore_deselected: assert property (p_ignore_deselected)
		else $error("bit shifted in while deselected");
	property p_hw_override;
		hw_shutdown_n_low |=> r.rx_cnt == 4'h0 && r.mode == $past(r.mode);
	endproperty
	a_hw_override: assert property (p_hw_override)
		else $error("control bits acted on in shutdown");

	c_ext_done: cover property (finish && r.clk_ext);
	c_int_done: cover property (finish && !r.clk_ext);
	c_overlap: cover property (start && r.st == adc_ctrl_pkg::ST_CONV);
	c_hw_abort: cover property (hw_shutdown_n_low && r.st == adc_ctrl_pkg::ST_CONV);
	c_restart: cover property (start && r.toggled);
endmodule

// [hw/adc_ctrl_pkg.sv]
// Purpose: shared constants and types for the serial converter control block
// Assumes: 100 MHz system clock
// Notes: status word is a packed struct, zero-extended onto the bus
package adc_ctrl_pkg;
	localparam int SYS_CLK_KHZ = 100000;
	localparam int POR_TIME_NS = 10000;
	localparam int POR_CYCLES = (POR_TIME_NS * (SYS_CLK_KHZ / 1000) + 999) / 1000;
	localparam int INT_FAST_KHZ = 1800;
	localparam int INT_SLOW_KHZ = 225;
	localparam logic [15:0] STEP_FAST = 16'(SYS_CLK_KHZ / INT_FAST_KHZ);
	localparam logic [15:0] STEP_SLOW = 16'(SYS_CLK_KHZ / INT_SLOW_KHZ);
	localparam logic [3:0] SAR_STEPS = 4'hC;
	localparam logic [3:0] OUT_BITS = 4'hC;
	localparam logic [3:0] ARM_BITS = 4'h7;
	localparam logic [3:0] CTRL_BITS = 4'h8;
	localparam int RESULT_W = 10;

	localparam logic [3:0] OFS_SAMPLE = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_RESULT = 4'hC;

	typedef enum logic [1:0] {
		PM_DEEP = 2'h0,
		PM_QUICK = 2'h1,
		PM_INT = 2'h2,
		PM_EXT = 2'h3
	} pmode_e;

	typedef enum logic [1:0] {ST_POR, ST_IDLE, ST_CONV, ST_DOWN} state_e;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
		logic hw_shutdown_n_n;
		logic hw_shutdown_n_fl;
	} pins_s;

	typedef struct packed {
		logic converted;
		logic strobe;
		logic ready;
		logic hw_down;
		logic busy;
		logic pdown;
		logic clk_ext;
		pmode_e mode;
	} status_s;

	typedef struct packed {
		state_e st;
		logic [15:0] cnt;
		logic [3:0] step;
		pins_s s1;
		pins_s s2;
		logic sclk_d;
		logic cs_n_d;
		logic [3:0] rx_cnt;
		logic [7:0] rx;
		logic [7:0] ctrl;
		pmode_e mode;
		logic clk_ext;
		logic [3:0] out_cnt;
		logic [15:0] shreg;
		logic dout;
		logic strobe;
		logic pdown;
		logic toggled;
		logic converted;
		logic [RESULT_W-1:0] sample;
		logic [11:0] result;
		logic wr_pend;
		logic [3:0] wr_addr;
		logic [31:0] rdata;
	} state_s;
endpackage

// [test/host_link_model.sv]
// Purpose: serial master in front of the converter control block
// Assumes: link clock of 80 ns made from 4 system cycles per half period
// Notes: shift_clock stands low outside frames
`timescale 1ns/1ps
module host_link_model (
	// System side
	input wire logic clk_i,
	input wire logic serial_out_i,
	// Link pins
	output logic shift_clock_o,
	output logic select_n_o,
	output logic serial_in_o
);
	initial begin
		shift_clock_o = 1'b0;
		select_n_o = 1'b1;
		serial_in_o = 1'b0;
	end

	// 80 ns per bit, above the floor; shutdown pin floats in the bench
	// so the internal-compensation ceiling and waits do not bind
	task automatic frame(input logic [31:0] word, input int n, output logic [31:0] rx);
		rx = '0;
		@(posedge clk_i);
		select_n_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			serial_in_o <= word[n-1-i];
			repeat (3) @(posedge clk_i);
			shift_clock_o <= 1'b1;
			// Capture after the rise, far from the next fall's update
			repeat (2) @(posedge clk_i);
			rx = {rx[30:0], serial_out_i};
			repeat (2) @(posedge clk_i);
			shift_clock_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		select_n_o <= 1'b1;
		// Released data line must not keep its last level
		serial_in_o <= ~serial_in_o;
	endtask
endmodule

// [test/serial_adc_framing_power_ctrl_test.sv]
// Purpose: self-checking bench for the converter framing and power control
// Assumes: POR_CYC shortened to 20, bus slave answers without wait states
// Notes: results come from the SAMPLE register value written first
`timescale 1ns/1ps
module serial_adc_framing_power_ctrl_test;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic sclk, sel_n, din, so, so_oe, strb, strb_oe;
	logic sd_n = 1'b1;
	logic sd_fl = 1'b1;
	logic [31:0] q, rx;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	adc_frame_ctrl #(.POR_CYC(20)) adc_frame_ctrl_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
		.shift_clock_i(sclk), .select_n_i(sel_n), .serial_in_i(din),
		.serial_out_o(so), .serial_out_oe_o(so_oe), .conversion_strobe_o(strb),
		.conversion_strobe_oe_o(strb_oe), .hw_shutdown_n_i(sd_n),
		.hw_shutdown_float_i(sd_fl)
	);

	host_link_model host_link_model_i (
		.clk_i(clk_i), .serial_out_i(so_oe ? so : 1'bz),
		.shift_clock_o(sclk), .select_n_o(sel_n), .serial_in_o(din)
	);

	task automatic final_report();
		if (err_total == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wait_idle();
		n = 0;
		do begin
			bus(1'b0, 32'h4, 32'h0);
			n++;
		end while (q[4] !== 1'b0 && n < 400);
		chk("busy", 32'(q[4]), 32'h0);
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		bus(1'b0, 32'h4, 32'h0);
		chk("ready early", 32'(q[6]), 32'h0);
		chk("hw down early", 32'(q[5]), 32'h0);
		// Link stays quiet until the power-on period is over
		repeat (30) @(posedge clk_i);
		chk("strobe", 32'(strb), 32'h1);
		bus(1'b0, 32'h4, 32'h0);
		chk("mode", 32'(q[1:0]), 32'(adc_ctrl_pkg::PM_INT));
		chk("ready", 32'(q[6]), 32'h1);
		chk("hresp", 32'(hresp), 32'h0);
		host_link_model_i.frame(32'h0, 16, rx);
		chk("idle dout", rx, 32'h0);
		bus(1'b0, 32'h4, 32'h0);
		chk("busy", 32'(q[4]), 32'h0);
		chk("dout oe", 32'(so_oe), 32'h0);
		bus(1'b1, 32'h0, 32'h2A5);
		// Second byte right after result bit 3, then cut after four result bits
		host_link_model_i.frame(32'h04180C30, 27, rx);
		chk("overlap bits", 32'(rx[17:11]), 32'h54);
		bus(1'b0, 32'h8, 32'h0);
		chk("overlap ctrl", q, 32'hC3);
		bus(1'b0, 32'h4, 32'h0);
		chk("cut busy", 32'(q[4]), 32'h1);
		// Only the select toggle arms this start bit
		host_link_model_i.frame(32'h00830000, 24, rx);
		chk("ext bits", 32'(rx[14:3]), 32'h00000A94);
		bus(1'b0, 32'hC, 32'h0);
		chk("result", q, 32'h00000A94);
		bus(1'b0, 32'h8, 32'h0);
		chk("ctrl", q, 32'h83);
		host_link_model_i.frame(32'h00000082, 8, rx);
		@(posedge clk_i);
		chk("strobe low", 32'(strb), 32'h0);
		chk("strobe oe", 32'(strb_oe), 32'h1);
		n = 0;
		while (strb !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk("strobe high", 32'(strb), 32'h1);
		host_link_model_i.frame(32'h0, 12, rx);
		chk("int bits", 32'(rx[10:1]), 32'h2A5);
		// Walk all four codes; the starts for codes 1 and 2 wake from the previous standby
		for (int m = 0; m < 4; m++) begin
			host_link_model_i.frame(32'({6'h20, 2'(m), 16'h0}), 24, rx);
			wait_idle();
			chk("mode", 32'(q[1:0]), 32'(m));
			chk("pdown", 32'(q[3]), 32'(m < 2));
		end
		host_link_model_i.frame(32'h00000082, 8, rx);
		@(posedge clk_i);
		sd_fl <= 1'b0;
		sd_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		bus(1'b0, 32'h4, 32'h0);
		chk("busy", 32'(q[4]), 32'h0);
		chk("hw down", 32'(q[5]), 32'h1);
		host_link_model_i.frame(32'h00810000, 24, rx);
		bus(1'b0, 32'h8, 32'h0);
		chk("ctrl", q, 32'h82);
		final_report();
	end
endmodule
